/* core/btp_parser.sv */
// Byte-serial TLV object parser with APB register slave
`timescale 1ns/100ps
`include "btp_cfg.svh"
module btp_parser import btp_pkg::*; #(
    parameter int LEN_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output btp_kind_t out_kind,
    output logic [7:0] out_data,
    output logic out_last,
    output logic obj_done,
    output logic [1:0] tag_class,
    output logic tag_cons,
    output logic std_tmpl,
    output logic app_tmpl,
    output logic spec_res,
    output logic pay_res,
    output logic err,
    output logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    btp_state_t st_q, st_d;
    btp_err_t fault, err_q;
    logic two_q;
    logic [15:0] tag_q;
    logic [LEN_W-1:0] len_q, vcnt_q, rem_q, len_val;
    logic [7:0] lacc_q;
    logic [1:0] lcnt_q;
    logic in_tmpl_q;
    logic en_q;
    logic [`BTP_IRQ_W-1:0] istat_q, imask_q, ev, w1c;
    logic acc, len_done, obj_end, tmpl_in, restart;
    logic setup, wr_en, mapped;
    logic [31:0] rd_w;

    btp_cls_if cif();
    btp_tag_class u_cls (
        .clk(clk),
        .rst(rst),
        .c(cif.cls)
    );
    assign cif.tag = tag_q;
    assign cif.two = two_q;
    assign cif.cons = tag_cons;
    assign std_tmpl = cif.std_t;
    assign app_tmpl = cif.app_t;
    assign spec_res = cif.spec_r;
    assign pay_res = cif.pay_r;

    assign acc = in_valid && in_ready;

    // Next state and fault detection for the accepted byte
    always_comb begin
        st_d = st_q;
        fault = ERR_NONE;
        len_done = 1'b0;
        len_val = '0;
        obj_end = 1'b0;
        tmpl_in = 1'b0;
        if (acc) begin
            case (st_q)
                ST_TAG1: begin
                    if (in_data[`BTP_LOW5] == `BTP_TAG_MULTI) begin
                        st_d = ST_TAG2;
                    end else if (in_data[`BTP_LOW5] == `BTP_TAG_NONE) begin
                        fault = ERR_TAG0;
                    end else begin
                        st_d = ST_LEN1;
                    end
                end
                ST_TAG2: begin
                    if (in_data[`BTP_CONT_BIT]) begin
                        fault = ERR_TAGLEN;
                    end else if (in_data[`BTP_LOW7] == `BTP_TNUM_NONE) begin
                        fault = ERR_TAG0;
                    end else begin
                        st_d = ST_LEN1;
                    end
                end
                ST_LEN1: begin
                    if (!in_data[`BTP_LONG_BIT]) begin
                        len_done = 1'b1;
                        len_val = LEN_W'(in_data[`BTP_LOW7]);
                    end else if (in_data[`BTP_LOW7] == `BTP_TNUM_NONE || in_data[`BTP_LOW7] > `BTP_LEN_MAXN) begin
                        fault = ERR_LENF;
                    end else begin
                        st_d = ST_LENX;
                    end
                end
                ST_LENX: begin
                    if (lcnt_q == 2'h1) begin
                        len_done = 1'b1;
                        len_val = LEN_W'({lacc_q, in_data});
                    end
                end
                ST_VAL: begin
                    if (vcnt_q == LEN_W'(1)) begin
                        obj_end = 1'b1;
                        st_d = ST_TAG1;
                    end
                end
                default: begin
                    st_d = st_q;
                end
            endcase
            if (len_done) begin
                if (len_val == '0) begin
                    obj_end = 1'b1;
                    st_d = ST_TAG1;
                end else if (in_tmpl_q && (tag_cons || len_val >= rem_q)) begin
                    fault = tag_cons ? ERR_NEST : ERR_OVER;
                end else if (tag_cons) begin
                    tmpl_in = 1'b1;
                    st_d = ST_TAG1;
                end else begin
                    st_d = ST_VAL;
                end
            end
            if (in_tmpl_q && rem_q == LEN_W'(1) && !obj_end && fault == ERR_NONE) begin
                fault = ERR_OVER;
            end
            if (fault != ERR_NONE) begin
                st_d = ST_ERR;
            end
        end
    end

    // Parser sequencing and counters
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            st_q <= ST_TAG1;
            err_q <= ERR_NONE;
            in_tmpl_q <= 1'b0;
            rem_q <= '0;
            vcnt_q <= '0;
            lcnt_q <= '0;
            lacc_q <= '0;
        end else if (acc) begin
            st_q <= st_d;
            if (fault != ERR_NONE) begin
                err_q <= fault;
            end
            if (st_q == ST_LEN1) begin
                lcnt_q <= in_data[`BTP_LCNT];
                lacc_q <= '0;
            end
            if (st_q == ST_LENX) begin
                lcnt_q <= lcnt_q - 2'h1;
                lacc_q <= in_data;
            end
            if (st_q == ST_VAL) begin
                vcnt_q <= vcnt_q - LEN_W'(1);
            end
            if (len_done) begin
                vcnt_q <= len_val;
            end
            if (tmpl_in) begin
                in_tmpl_q <= 1'b1;
                rem_q <= len_val;
            end else if (in_tmpl_q) begin
                rem_q <= rem_q - LEN_W'(1);
                if (rem_q == LEN_W'(1)) begin
                    in_tmpl_q <= 1'b0;
                end
            end
        end
    end

    // Tag and length capture
    always_ff @(posedge clk) begin
        if (rst) begin
            tag_class <= '0;
            tag_cons <= 1'b0;
            two_q <= 1'b0;
            tag_q <= '0;
            len_q <= '0;
        end else if (acc) begin
            if (st_q == ST_TAG1) begin
                tag_class <= in_data[`BTP_CLS];
                tag_cons <= in_data[`BTP_FORM_BIT];
                two_q <= in_data[`BTP_LOW5] == `BTP_TAG_MULTI;
                tag_q <= {8'h00, in_data};
            end
            if (st_q == ST_TAG2) begin
                tag_q <= {tag_q[7:0], in_data};
            end
            if (len_done) begin
                len_q <= len_val;
            end
        end
    end

    // Stream outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            in_ready <= 1'b0;
            out_valid <= 1'b0;
            out_kind <= K_TAG;
            out_data <= '0;
            out_last <= 1'b0;
            obj_done <= 1'b0;
            err <= 1'b0;
        end else begin
            in_ready <= en_q && st_d != ST_ERR && !restart;
            out_valid <= acc && fault == ERR_NONE;
            out_data <= in_data;
            out_last <= acc && obj_end && fault == ERR_NONE;
            obj_done <= acc && obj_end && fault == ERR_NONE;
            err <= st_d == ST_ERR && !restart;
            if (st_q == ST_TAG1 || st_q == ST_TAG2) begin
                out_kind <= K_TAG;
            end else if (st_q == ST_VAL) begin
                out_kind <= K_VAL;
            end else begin
                out_kind <= K_LEN;
            end
        end
    end

    // APB slave: one wait-free access phase after each setup
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready;
    assign restart = wr_en && paddr == `BTP_A_CTRL && pwdata[`BTP_RESTART_BIT];
    assign w1c = (wr_en && paddr == `BTP_A_ISTAT) ? pwdata[`BTP_IRQ_W-1:0] : '0;

    always_comb begin
        rd_w = '0;
        mapped = 1'b1;
        case (paddr)
            `BTP_A_CTRL: rd_w[`BTP_EN_BIT] = en_q;
            `BTP_A_STAT: rd_w[5:0] = {err_q, in_tmpl_q, st_q != ST_TAG1, st_q == ST_ERR};
            `BTP_A_ISTAT: rd_w[`BTP_IRQ_W-1:0] = istat_q;
            `BTP_A_IMASK: rd_w[`BTP_IRQ_W-1:0] = imask_q;
            `BTP_A_TAG: rd_w[15:0] = tag_q;
            `BTP_A_LEN: rd_w[LEN_W-1:0] = len_q;
            `BTP_A_INFO: rd_w[7:0] = {pay_res, spec_res, app_tmpl, std_tmpl, two_q, tag_cons, tag_class};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata <= rd_w;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            en_q <= `BTP_EN_RST;
            imask_q <= '0;
        end else if (wr_en) begin
            if (paddr == `BTP_A_CTRL) begin
                en_q <= pwdata[`BTP_EN_BIT];
            end
            if (paddr == `BTP_A_IMASK) begin
                imask_q <= pwdata[`BTP_IRQ_W-1:0];
            end
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle
    always_comb begin
        ev = '0;
        ev[`BTP_IRQ_OBJ] = acc && obj_end && fault == ERR_NONE;
        ev[`BTP_IRQ_ERR] = acc && fault != ERR_NONE;
        ev[`BTP_IRQ_TMPL] = tmpl_in;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            istat_q <= '0;
            irq <= 1'b0;
        end else begin
            istat_q <= (istat_q & ~w1c) | ev;
            irq <= |(istat_q & imask_q);
        end
    end

    property p_class;
        acc && st_q == ST_TAG1 |=> tag_class == $past(in_data[7:6]);
    endproperty
    a_class: assert property (p_class) else $error("class not taken from tag");
    property p_form;
        acc && st_q == ST_TAG1 |=> tag_cons == $past(in_data[5]);
    endproperty
    a_form: assert property (p_form) else $error("form flag not taken from tag");
    property p_multi;
        acc && st_q == ST_TAG1 && in_data[4:0] == 5'h1F && rem_q != LEN_W'(1) |=> st_q == ST_TAG2;
    endproperty
    a_multi: assert property (p_multi) else $error("second tag byte not expected");
    property p_cont;
        acc && st_q == ST_TAG2 && in_data[7] |=> st_q == ST_ERR ##1 !in_ready;
    endproperty
    a_cont: assert property (p_cont) else $error("three-byte tag accepted");
    property p_short_len;
        acc && st_q == ST_LEN1 && in_data[7:0] != 8'h00 && !in_data[7] && !tag_cons && !in_tmpl_q
            |=> st_q == ST_VAL && vcnt_q == LEN_W'($past(in_data[6:0]));
    endproperty
    a_short_len: assert property (p_short_len) else $error("short length misdecoded");
    property p_long_len;
        acc && st_q == ST_LEN1 && in_data[7] && (in_data[6:0] == 7'h01 || in_data[6:0] == 7'h02)
            && rem_q != LEN_W'(1) |=> st_q == ST_LENX;
    endproperty
    a_long_len: assert property (p_long_len) else $error("long length not followed");
    property p_len_bad;
        acc && st_q == ST_LEN1 && in_data[7] && (in_data[6:0] == 7'h00 || in_data[6:0] > 7'h02)
            |=> st_q == ST_ERR && err_q == ERR_LENF;
    endproperty
    a_len_bad: assert property (p_len_bad) else $error("oversize length field accepted");
    property p_zero_len;
        acc && st_q == ST_LEN1 && in_data == 8'h00 |=> st_q == ST_TAG1 && obj_done;
    endproperty
    a_zero_len: assert property (p_zero_len) else $error("empty object not closed");
    property p_err_stop;
        st_q == ST_ERR && !restart |=> !in_ready && err;
    endproperty
    a_err_stop: assert property (p_err_stop) else $error("parser runs after error");
endmodule // btp_parser

/* include/btp_cfg.svh */
// Constants for the TLV object parser: addresses, field positions, tag ranges
`ifndef BTP_CFG_SVH
`define BTP_CFG_SVH
`define BTP_A_CTRL 12'h000
`define BTP_A_STAT 12'h004
`define BTP_A_ISTAT 12'h008
`define BTP_A_IMASK 12'h00C
`define BTP_A_TAG 12'h010
`define BTP_A_LEN 12'h014
`define BTP_A_INFO 12'h018
`define BTP_EN_BIT 0
`define BTP_RESTART_BIT 1
`define BTP_EN_RST 1'b1
`define BTP_IRQ_W 3
`define BTP_IRQ_OBJ 0
`define BTP_IRQ_ERR 1
`define BTP_IRQ_TMPL 2
`define BTP_CLS 7:6
`define BTP_FORM_BIT 5
`define BTP_LOW5 4:0
`define BTP_LOW7 6:0
`define BTP_LCNT 1:0
`define BTP_CONT_BIT 7
`define BTP_LONG_BIT 7
`define BTP_TAG_MULTI 5'h1F
`define BTP_TAG_NONE 5'h00
`define BTP_TNUM_NONE 7'h00
`define BTP_LEN_MAXN 7'h02
`define BTP_T_STD0 16'h0061
`define BTP_T_STD1 16'h006F
`define BTP_T_APP_LO 16'h0070
`define BTP_T_APP_HI 16'h007F
`define BTP_T_SP1_LO 16'h0080
`define BTP_T_SP1_HI 16'h009E
`define BTP_T_SP2_LO 16'h9F01
`define BTP_T_SP2_HI 16'h9F4F
`define BTP_T_PAY_LO 16'h9F50
`define BTP_T_PAY_HI 16'h9F7F
`endif

/* include/btp_pkg.sv */
// Types shared by the TLV object parser
package btp_pkg;
    typedef enum logic [2:0] {ST_TAG1, ST_TAG2, ST_LEN1, ST_LENX, ST_VAL, ST_ERR} btp_state_t;
    typedef enum logic [1:0] {K_TAG, K_LEN, K_VAL} btp_kind_t;
    typedef enum logic [2:0] {ERR_NONE, ERR_TAG0, ERR_TAGLEN, ERR_LENF, ERR_OVER, ERR_NEST} btp_err_t;
endpackage

/* include/btp_cls_if.sv */
// Decoded tag handed from the parser to the tag classifier
`timescale 1ns/100ps
interface btp_cls_if;
    logic [15:0] tag;
    logic two;
    logic cons;
    logic std_t;
    logic app_t;
    logic spec_r;
    logic pay_r;
    modport prs (output tag, output two, output cons, input std_t, input app_t, input spec_r, input pay_r);
    modport cls (input tag, input two, input cons, output std_t, output app_t, output spec_r, output pay_r);
endinterface

/* core/btp_tag_class.sv */
// Tag classifier: template and reserved range flags
`timescale 1ns/100ps
`include "btp_cfg.svh"
module btp_tag_class (
    input wire logic clk,
    input wire logic rst,
    btp_cls_if.cls c
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    always_ff @(posedge clk) begin
        if (rst) begin
            c.std_t <= 1'b0;
            c.app_t <= 1'b0;
            c.spec_r <= 1'b0;
            c.pay_r <= 1'b0;
        end else begin
            c.std_t <= !c.two && (c.tag == `BTP_T_STD0 || c.tag == `BTP_T_STD1);
            c.app_t <= !c.two && c.tag >= `BTP_T_APP_LO && c.tag <= `BTP_T_APP_HI;
            c.spec_r <= !c.cons && ((!c.two && c.tag >= `BTP_T_SP1_LO && c.tag <= `BTP_T_SP1_HI)
                || (c.two && c.tag >= `BTP_T_SP2_LO && c.tag <= `BTP_T_SP2_HI));
            c.pay_r <= !c.cons && c.two && c.tag >= `BTP_T_PAY_LO && c.tag <= `BTP_T_PAY_HI;
        end
    end

    property p_std_tmpl;
        !c.two && (c.tag == 16'h0061 || c.tag == 16'h006F) |=> c.std_t && !c.app_t;
    endproperty
    a_std_tmpl: assert property (p_std_tmpl) else $error("standard template not flagged");
    property p_pay_res;
        c.two && !c.cons && c.tag >= 16'h9F50 && c.tag <= 16'h9F7F |=> c.pay_r && !c.spec_r;
    endproperty
    a_pay_res: assert property (p_pay_res) else $error("payment range misclassified");
    property p_spec_res;
        c.two && !c.cons && c.tag >= 16'h9F01 && c.tag <= 16'h9F4F |=> c.spec_r && !c.pay_r;
    endproperty
    a_spec_res: assert property (p_spec_res) else $error("reserved range misclassified");
endmodule // btp_tag_class

/* dv/btp_src_model.sv */
// Upstream byte source model for the TLV parser
`timescale 1ns/100ps
module btp_src_model (
    input wire logic clk,
    input wire logic in_ready,
    output logic in_valid,
    output logic [7:0] in_data
);
    initial begin
        in_valid = 1'b0;
        in_data = 8'h00;
    end
    // Offer one byte after an optional stall, hold it until taken
    task automatic send(input logic [7:0] d, input int gap);
        if (gap > 0) begin
            in_valid <= 1'b0;
            in_data <= ~in_data;
            repeat (gap) @(posedge clk);
        end
        in_valid <= 1'b1;
        in_data <= d;
        do @(posedge clk); while (in_ready !== 1'b1);
    endtask
    // Released line carries scrambled data, not the last byte
    task automatic idle();
        in_valid <= 1'b0;
        in_data <= ~in_data;
        @(posedge clk);
    endtask
endmodule // btp_src_model

/* dv/tb_btp_parser.sv */
// Self-checking bench for the TLV object parser
`timescale 1ns/100ps
`include "btp_cfg.svh"
module tb_btp_parser;
    import btp_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic in_valid, in_ready, out_valid, out_last, obj_done, tag_cons;
    logic std_tmpl, app_tmpl, spec_res, pay_res, err, irq;
    logic [7:0] in_data, out_data;
    logic [1:0] tag_class;
    btp_kind_t out_kind;
    logic [19:0] exp_q[$];
    logic [19:0] e, g;
    int fails = 0, total_checks = 0, cyc = 0, seed = 32'h55baeeaf;
    // Malformed byte and expected status for each error case
    logic [7:0] bad_b[6] = '{8'h00, 8'h83, 8'h81, 8'h01, 8'h01, 8'h00};
    logic [31:0] stat_x[6] = '{32'h0000_0009, 32'h0000_0019, 32'h0000_0011, 32'h0000_0021, 32'h0000_0029,
                               32'h0000_0009};

    btp_parser #(.LEN_W(16)) i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
        .out_kind(out_kind), .out_data(out_data), .out_last(out_last), .obj_done(obj_done),
        .tag_class(tag_class), .tag_cons(tag_cons), .std_tmpl(std_tmpl), .app_tmpl(app_tmpl),
        .spec_res(spec_res), .pay_res(pay_res), .err(err), .irq(irq));
    btp_src_model i_src (.clk(clk), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_byte(input logic [19:0] got, input logic [19:0] exp);
        cmp_reg({12'h000, got}, {12'h000, exp});
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        cmp_reg(rd & m, x);
    endtask
    // Note the expected output, then offer the byte
    task automatic put(input logic [1:0] k, input logic [7:0] d, input logic l, input logic c, input logic [6:0] f);
        exp_q.push_back({c, f, k, l, l, d});
        i_src.send(d, (($random(seed) & 3) == 0) ? 2 : 0);
    endtask
    task automatic tlv(input logic [15:0] t, input logic [23:0] l, input int ln, input int vn, input logic hdr,
                       input logic [6:0] f);
        if (t[15:8] != 8'h00) put(K_TAG, t[15:8], 1'b0, 1'b0, 7'h00);
        put(K_TAG, t[7:0], 1'b0, 1'b0, 7'h00);
        for (int i = ln - 1; i >= 0; i--) put(K_LEN, l[8*i +: 8], i == 0 && vn == 0 && !hdr, i == ln - 1, f);
        for (int i = 0; i < vn; i++) put(K_VAL, 8'($random(seed)), i == vn - 1, 1'b0, 7'h00);
    endtask
    task automatic drain();
        i_src.idle();
        for (int i = 0; i < 50 && exp_q.size() > 0; i++) @(posedge clk);
    endtask

    // Output watcher takes the oldest note for each shown byte
    always @(posedge clk) begin
        if (out_valid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 20'hF_FFFF;
            g = {e[19], e[19] ? {tag_class, tag_cons, std_tmpl, app_tmpl, spec_res, pay_res} : e[18:12],
                 out_kind, out_last, obj_done, out_data};
            cmp_byte(g, e);
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk(`BTP_A_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
        rchk(`BTP_A_IMASK, 32'hFFFF_FFFF, 32'h0000_0000);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        cmp_reg({31'h0, serr}, 32'h0000_0001);
        cmp_reg(rd, 32'h0000_0000);
        tlv(16'h005A, 24'h02, 1, 2, 1'b0, 7'b0100000);
        tlv(16'h001A, 24'h01, 1, 1, 1'b0, 7'b0000000);
        tlv(16'h009A, 24'h01, 1, 1, 1'b0, 7'b1000010);
        tlv(16'h00DA, 24'h01, 1, 1, 1'b0, 7'b1100000);
        tlv(16'h9F02, 24'h8103, 2, 3, 1'b0, 7'b1000010);
        tlv(16'h9F55, 24'h820100, 3, 256, 1'b0, 7'b1000001);
        drain();
        rchk(`BTP_A_LEN, 32'h0000_FFFF, 32'h0000_0100);
        rchk(`BTP_A_TAG, 32'h0000_FFFF, 32'h0000_9F55);
        tlv(16'h009A, 24'h00, 1, 0, 1'b0, 7'b1000010);
        tlv(16'h0070, 24'h03, 1, 0, 1'b1, 7'b0110100);
        tlv(16'h009A, 24'h01, 1, 1, 1'b0, 7'b1000010);
        tlv(16'h0061, 24'h00, 1, 0, 1'b0, 7'b0111000);
        drain();
        rchk(`BTP_A_ISTAT, 32'h0000_0007, 32'h0000_0005);
        apb(1'b1, `BTP_A_IMASK, 32'h0000_0002);
        for (int i = 0; i < 6; i++) begin
            if (i == 1) put(K_TAG, 8'h5A, 1'b0, 1'b0, 7'h00);
            if (i == 2 || i == 5) put(K_TAG, 8'h9F, 1'b0, 1'b0, 7'h00);
            if (i == 3 || i == 4) begin
                put(K_TAG, 8'h70, 1'b0, 1'b0, 7'h00);
                put(K_LEN, (i == 3) ? 8'h02 : 8'h04, 1'b0, 1'b1, 7'b0110100);
                put(K_TAG, (i == 3) ? 8'h9A : 8'h61, 1'b0, 1'b0, 7'h00);
            end
            i_src.send(bad_b[i], 0);
            i_src.idle();
            repeat (3) @(posedge clk);
            cmp_reg({31'h0, irq & err & ~in_ready}, 32'h0000_0001);
            rchk(`BTP_A_STAT, 32'h0000_0039, stat_x[i]);
            apb(1'b1, `BTP_A_ISTAT, 32'h0000_0007);
            apb(1'b1, `BTP_A_CTRL, 32'h0000_0003);
            repeat (2) @(posedge clk);
            cmp_reg({31'h0, irq | err}, 32'h0000_0000);
        end
        apb(1'b1, `BTP_A_CTRL, 32'h0000_0000);
        @(posedge clk);
        cmp_reg({31'h0, in_ready}, 32'h0000_0000);
        apb(1'b1, `BTP_A_CTRL, 32'h0000_0001);
        tlv(16'h005A, 24'h01, 1, 1, 1'b0, 7'b0100000);
        drain();
        cmp_reg(exp_q.size(), 32'h0000_0000);
        report_and_stop();
    end
endmodule // tb_btp_parser
